// ### rsph_regs.svh
// register offsets, field positions and reset values of the pipeline_pending block
`ifndef RSPH_REGS_SVH
`define RSPH_REGS_SVH

`define RSPH_SEL_BASE      3'h2
`define RSPH_SEL_OFFSET    16'h0003
`define RSPH_IRQ_EN_OFFSET 16'h0004
`define RSPH_POLL_LO       16'h1000

`define RSPH_BIT_FIELD     0
`define RSPH_BIT_VSYNC     1
`define RSPH_BIT_PAGE      2
`define RSPH_BIT_DMA_S     3
`define RSPH_BIT_DMA_I     4
`define RSPH_BIT_PIPE_S    5
`define RSPH_BIT_PIPE_I    6
`define RSPH_BIT_PKT_S     7
`define RSPH_BIT_PKT_I     8
`define RSPH_BIT_HALT      9

`define RSPH_INT_MASK      32'h0000_0156
`define RSPH_IRQ_EN_RESET  5'h00
`define RSPH_PKT_MAIN_BIT  26

`endif

// ### rsph_pkg.sv
// types shared by the pipeline_pending and packet header block
package rsph_pkg;

    typedef enum logic [1:0] {
        RSPH_CTX_NONE       = 2'h0,
        RSPH_CTX_PER_PACKET = 2'h1,
        RSPH_CTX_PER_PRIM   = 2'h2,
        RSPH_CTX_PER_VERTEX = 2'h3
    } rsph_ctx_e;

    typedef enum logic [2:0] {
        RSPH_PRIM_POINTS     = 3'h0,
        RSPH_PRIM_LINES      = 3'h1,
        RSPH_PRIM_WIDE       = 3'h2,
        RSPH_PRIM_QUADS      = 3'h3,
        RSPH_PRIM_BLOCK_RD   = 3'h4,
        RSPH_PRIM_BLOCK_WR   = 3'h5,
        RSPH_PRIM_WIDE_4     = 3'h6,
        RSPH_PRIM_WIDE_2     = 3'h7
    } rsph_prim_e;

    typedef enum logic [1:0] {
        RSPH_BUS_IDLE = 2'h0,
        RSPH_BUS_ACK  = 2'h1
    } rsph_bus_e;

    // decoded first word of a command packet
    typedef struct packed {
        logic [7:0] primitive_count;
        logic [1:0] map_id_word_count;
        logic [3:0] instruction_count;
        rsph_ctx_e  depth1_eq_format;
        rsph_ctx_e  depth0_eq_format;
        rsph_ctx_e  colour1_eq_format;
        rsph_ctx_e  colour0_eq_format;
        logic [1:0] depth_mask_format;
        logic [1:0] coverage_mask_format;
        logic [1:0] clip_rect_format;
        logic       end_excluded;
        rsph_prim_e primitive_type;
    } rsph_header_s;

    // context presence derived from the header
    typedef struct packed {
        logic       clip_present;
        logic       coverage_mask_present;
        logic       depth_mask_present;
        logic       count_illegal;
        logic [2:0] map_id_count_half;
    } rsph_ctx_info_s;

    // event inputs from the pipeline and video side
    typedef struct packed {
        logic packet_blocked;
        logic pipeline_pending;
        logic dma_map_pending;
        logic page_fault_wait;
        logic vsync_event;
        logic stereo_left;
    } rsph_events_s;

endpackage

// ### rsph_status_header.sv
// render engine status register, polling decode and packet header decoder
`timescale 1ns/1ps
`include "rsph_regs.svh"

// Contract
// - status register sits at base with bits 20:18 = 2, 17:2 = 3, 1:0 zero
// - bit 7 shows packet blocked; polling reads return the same bit
// - bit 5 shows unrendered packet data still in the pipeline
// - bit 3 shows pending DMA map access; also the separate DMA status
// - flags 8, 6, 4 set on falling edges of bits 7, 5, 3
// - bit 2 set while waiting for CPU page fault handling
// - bit 1 set on a vertical sync event
// - bit 9 high halts packet processing; DMA map access still proceeds; halt blocks only header capture, a polling read still pulses packet_start
// - bit 0 shows stereo left view or retrace before it
// - bits 7, 5, 3, 0 read-only; bits 31:10 undefined, read zero
// - only device sets flags; CPU writes clear them; halt is read-write
// - header bits 2:0 give the primitive type
// - header bit 3: 0 includes second endpoint, 1 excludes it
// - header bits 5:4 clip format; nonzero means two context words
// - header bits 7:6 coverage mask format; nonzero means mask present
// - header bits 9:8 depth mask format; nonzero means one word present
// - four 2-bit plane equation formats at 11:10, 13:12, 15:14, 17:16
// - header bits 21:18 are the instruction count
// - header bits 23:22 are map id words, two ids per word
// - header bits 31:24 primitive count, never zero from the builder
// - polling read forms packet address 26:12 from address 17:3
// - first fetched packet word is the header governing the rest
module rsph_status_header (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic [20:0]           avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    input  wire rsph_pkg::rsph_events_s events,
    input  wire logic                  header_valid,
    input  wire logic [31:0]           header_word,
    output rsph_pkg::rsph_header_s     header_out,
    output rsph_pkg::rsph_ctx_info_s   ctx_out,
    output logic                       header_out_valid,
    output logic                       packet_halt,
    output logic                       dma_status,
    output logic [26:0]                packet_address,
    output logic                       packet_in_main,
    output logic                       packet_start,
    output logic                       irq
);

    rsph_pkg::rsph_bus_e bus_state_reg;
    logic [31:0]         rd_data_reg;
    logic                halt_reg;
    logic                pkt_flag_reg;
    logic                pipe_flag_reg;
    logic                dma_flag_reg;
    logic                page_flag_reg;
    logic                vsync_flag_reg;
    logic [4:0]          irq_en_reg;
    logic                pkt_s_d_reg;
    logic                pipe_s_d_reg;
    logic                dma_s_d_reg;
    logic [26:0]         pkt_addr_reg;
    logic                pkt_start_reg;
    rsph_pkg::rsph_header_s   hdr_reg;
    rsph_pkg::rsph_ctx_info_s ctx_reg;
    logic                hdr_valid_reg;
    logic                dma_status_reg;
    logic                irq_reg;
    logic                waitrequest_reg;

    logic        sel_status;
    logic        sel_irq_en;
    logic        sel_poll;
    logic        bus_take;
    logic        wr_status;
    logic [31:0] status_word;
    logic [4:0]  flags;
    logic        pkt_fall;
    logic        pipe_fall;
    logic        dma_fall;

    // true when the word offset field matches the given register
    function automatic logic offset_hit(input logic [20:0] addr, input logic [15:0] off);
        offset_hit = (addr[20:18] == `RSPH_SEL_BASE) && (addr[17:2] == off) && (addr[1:0] == 2'h0);
    endfunction

    assign sel_status = offset_hit(avs_address, `RSPH_SEL_OFFSET);
    assign sel_irq_en = offset_hit(avs_address, `RSPH_IRQ_EN_OFFSET);
    // polling window: base-2 doublewords, bits 2:0 zero, bits 17:3 nonzero, but never the irq enable word
    assign sel_poll   = (avs_address[20:18] == `RSPH_SEL_BASE) && (avs_address[2:0] == 3'h0)
                        && (avs_address[17:3] != 15'h0) && !sel_irq_en;
    assign bus_take   = (avs_read || avs_write) && (bus_state_reg == rsph_pkg::RSPH_BUS_IDLE);
    assign wr_status  = bus_take && avs_write && sel_status && avs_byteenable[1:0] != 2'h0;

    assign pkt_fall  = pkt_s_d_reg && !events.packet_blocked;
    assign pipe_fall = pipe_s_d_reg && !events.pipeline_pending;
    assign dma_fall  = dma_s_d_reg && !events.dma_map_pending;

    always_comb begin
        status_word = 32'h0;
        status_word[`RSPH_BIT_HALT]   = halt_reg;
        status_word[`RSPH_BIT_PKT_I]  = pkt_flag_reg;
        status_word[`RSPH_BIT_PKT_S]  = events.packet_blocked;
        status_word[`RSPH_BIT_PIPE_I] = pipe_flag_reg;
        status_word[`RSPH_BIT_PIPE_S] = events.pipeline_pending;
        status_word[`RSPH_BIT_DMA_I]  = dma_flag_reg;
        status_word[`RSPH_BIT_DMA_S]  = events.dma_map_pending;
        status_word[`RSPH_BIT_PAGE]   = page_flag_reg;
        status_word[`RSPH_BIT_VSYNC]  = vsync_flag_reg;
        status_word[`RSPH_BIT_FIELD]  = events.stereo_left;
    end

    assign flags = {pkt_flag_reg, pipe_flag_reg, dma_flag_reg, page_flag_reg, vsync_flag_reg};

    // one wait cycle per access: request taken, answer on the next edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_state_reg <= rsph_pkg::RSPH_BUS_IDLE;
        end else if (bus_take) begin
            bus_state_reg <= rsph_pkg::RSPH_BUS_ACK;
        end else begin
            bus_state_reg <= rsph_pkg::RSPH_BUS_IDLE;
        end
    end

    // waitrequest from its own flop: low only in the cycle after a request is taken
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            waitrequest_reg <= 1'b1;
        end else begin
            waitrequest_reg <= !bus_take;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_reg <= 32'h0;
        end else if (bus_take && avs_read) begin
            if (sel_status) begin
                rd_data_reg <= status_word;
            end else if (sel_irq_en) begin
                rd_data_reg <= {27'h0, irq_en_reg};
            end else if (sel_poll) begin
                rd_data_reg <= {24'h0, events.packet_blocked, 7'h0};
            end else begin
                rd_data_reg <= 32'h0;
            end
        end
    end

    // a free engine starts the fetch at the address the polling read carries
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pkt_addr_reg  <= 27'h0;
            pkt_start_reg <= 1'b0;
        end else begin
            pkt_start_reg <= bus_take && avs_read && sel_poll && !events.packet_blocked;
            if (bus_take && avs_read && sel_poll) begin
                pkt_addr_reg <= {avs_address[17:3], 12'h000};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halt_reg <= 1'b0;
        end else if (wr_status) begin
            halt_reg <= avs_writedata[`RSPH_BIT_HALT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_en_reg <= `RSPH_IRQ_EN_RESET;
        end else if (bus_take && avs_write && sel_irq_en && avs_byteenable[0]) begin
            irq_en_reg <= avs_writedata[4:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pkt_s_d_reg  <= 1'b0;
            pipe_s_d_reg <= 1'b0;
            dma_s_d_reg  <= 1'b0;
        end else begin
            pkt_s_d_reg  <= events.packet_blocked;
            pipe_s_d_reg <= events.pipeline_pending;
            dma_s_d_reg  <= events.dma_map_pending;
        end
    end

    // a write of one clears a flag; a write can never set one and a new event wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pkt_flag_reg   <= 1'b0;
            pipe_flag_reg  <= 1'b0;
            dma_flag_reg   <= 1'b0;
            page_flag_reg  <= 1'b0;
            vsync_flag_reg <= 1'b0;
        end else begin
            pkt_flag_reg   <= pkt_fall  || (pkt_flag_reg  && !(wr_status && avs_writedata[`RSPH_BIT_PKT_I]));
            pipe_flag_reg  <= pipe_fall || (pipe_flag_reg && !(wr_status && avs_writedata[`RSPH_BIT_PIPE_I]));
            dma_flag_reg   <= dma_fall  || (dma_flag_reg  && !(wr_status && avs_writedata[`RSPH_BIT_DMA_I]));
            page_flag_reg  <= events.page_fault_wait
                              || (page_flag_reg && !(wr_status && avs_writedata[`RSPH_BIT_PAGE]));
            vsync_flag_reg <= events.vsync_event
                              || (vsync_flag_reg && !(wr_status && avs_writedata[`RSPH_BIT_VSYNC]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_reg        <= 1'b0;
            dma_status_reg <= 1'b0;
        end else begin
            irq_reg        <= |(flags & irq_en_reg);
            dma_status_reg <= events.dma_map_pending;
        end
    end

    // header register; halted engine takes no new packet, DMA status keeps running
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hdr_reg       <= '0;
            ctx_reg       <= '0;
            hdr_valid_reg <= 1'b0;
        end else begin
            hdr_valid_reg <= header_valid && !halt_reg;
            if (header_valid && !halt_reg) begin
                hdr_reg.primitive_type       <= rsph_pkg::rsph_prim_e'(header_word[2:0]);
                hdr_reg.end_excluded         <= header_word[3];
                hdr_reg.clip_rect_format     <= header_word[5:4];
                hdr_reg.coverage_mask_format <= header_word[7:6];
                hdr_reg.depth_mask_format    <= header_word[9:8];
                hdr_reg.colour0_eq_format    <= rsph_pkg::rsph_ctx_e'(header_word[11:10]);
                hdr_reg.colour1_eq_format    <= rsph_pkg::rsph_ctx_e'(header_word[13:12]);
                hdr_reg.depth0_eq_format     <= rsph_pkg::rsph_ctx_e'(header_word[15:14]);
                hdr_reg.depth1_eq_format     <= rsph_pkg::rsph_ctx_e'(header_word[17:16]);
                hdr_reg.instruction_count    <= header_word[21:18];
                hdr_reg.map_id_word_count    <= header_word[23:22];
                hdr_reg.primitive_count      <= header_word[31:24];
                ctx_reg.clip_present          <= header_word[5:4] != 2'h0;
                ctx_reg.coverage_mask_present <= header_word[7:6] != 2'h0;
                ctx_reg.depth_mask_present    <= header_word[9:8] != 2'h0;
                ctx_reg.count_illegal         <= header_word[31:24] == 8'h00;
                ctx_reg.map_id_count_half     <= {header_word[23:22], 1'b0};
            end
        end
    end

    assign avs_readdata     = rd_data_reg;
    assign avs_waitrequest  = waitrequest_reg;
    assign header_out       = hdr_reg;
    assign ctx_out          = ctx_reg;
    assign header_out_valid = hdr_valid_reg;
    assign packet_halt      = halt_reg;
    assign dma_status       = dma_status_reg;
    assign packet_address   = pkt_addr_reg;
    assign packet_in_main   = pkt_addr_reg[`RSPH_PKT_MAIN_BIT];
    assign packet_start     = pkt_start_reg;
    assign irq              = irq_reg;

    halt_follows_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_status |=> packet_halt == $past(avs_writedata[`RSPH_BIT_HALT])) else $error("halt bit not written");
    halt_blocks_header_a: assert property (@(posedge sys_clk) disable iff (rst)
        halt_reg |=> !header_out_valid) else $error("header taken while halted");
    pkt_flag_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(events.packet_blocked) |=> pkt_flag_reg) else $error("packet flag missed");
    pipe_flag_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(events.pipeline_pending) |=> pipe_flag_reg) else $error("pipeline flag missed");
    dma_flag_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(events.dma_map_pending) |=> dma_flag_reg) else $error("dma flag missed");
    flag_no_cpu_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!pipe_flag_reg && !pipe_fall) |=> !pipe_flag_reg) else $error("flag set without event");
    vsync_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        events.vsync_event |=> vsync_flag_reg) else $error("vsync flag missed");
    page_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        events.page_fault_wait |=> page_flag_reg) else $error("page flag missed");
    status_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        (bus_take && avs_read && sel_status) |=> !avs_waitrequest && avs_readdata[31:10] == 22'h0
        && avs_readdata[5] == $past(events.pipeline_pending)) else $error("status read wrong");
    dma_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1 |=> dma_status == $past(events.dma_map_pending)) else $error("dma status copy wrong");
    poll_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
        (bus_take && avs_read && sel_poll) |=> packet_address[26:12] == $past(avs_address[17:3])
        && packet_address[11:0] == 12'h000) else $error("packet address wrong");
    poll_blocked_a: assert property (@(posedge sys_clk) disable iff (rst)
        (bus_take && avs_read && sel_poll && events.packet_blocked) |=> !packet_start) else $error("fetch while blocked");
    header_count_a: assert property (@(posedge sys_clk) disable iff (rst)
        (header_valid && !halt_reg) |=> header_out_valid && header_out.primitive_count == $past(header_word[31:24])
        && header_out.instruction_count == $past(header_word[21:18])) else $error("header decode wrong");
    irq_follows_a: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1 |=> irq == $past(|(flags & irq_en_reg))) else $error("irq wrong");

    poll_start_c: cover property (@(posedge sys_clk) disable iff (rst) packet_start);
    flag_clear_c: cover property (@(posedge sys_clk) disable iff (rst) $fell(pipe_flag_reg));
    halt_c: cover property (@(posedge sys_clk) disable iff (rst) halt_reg && header_valid);
    irq_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
    poll_blocked_c: cover property (@(posedge sys_clk) disable iff (rst)
        bus_take && avs_read && sel_poll && events.packet_blocked);

endmodule

// ### rsph_host.sv
// host cpu model: avalon master for the status block and header source
`timescale 1ns/1ps
module rsph_host (
    input  wire logic        sys_clk,
    output logic      [20:0] avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic             header_valid,
    output logic      [31:0] header_word
);
    int timeouts = 0;

    initial begin
        avs_address    = 21'h00_0000;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hF;
        header_valid   = 1'b0;
        header_word    = 32'h0000_0000;
    end

    // one word per request, held until waitrequest is seen low at a rising edge
    task automatic xfer(input bit wr, input logic [20:0] a, input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64)
            timeouts++;
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // released lines do not keep their last value
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask

    // one header word offered for a single cycle
    task automatic send_header(input logic [31:0] w);
        @(posedge sys_clk);
        header_valid <= 1'b1;
        header_word  <= w;
        @(posedge sys_clk);
        header_valid <= 1'b0;
        header_word  <= ~w;
    endtask
endmodule

// ### tb.sv
// self-checking bench for the pipeline_pending and packet header block
`timescale 1ns/1ps
`include "rsph_regs.svh"
module tb;
    localparam logic [20:0] STAT_ADDR = {`RSPH_SEL_BASE, `RSPH_SEL_OFFSET, 2'h0};
    localparam logic [20:0] IRQ_ADDR  = {`RSPH_SEL_BASE, `RSPH_IRQ_EN_OFFSET, 2'h0};

    logic                     sys_clk = 1'b0;
    logic                     rst = 1'b1;
    logic [20:0]              avs_address;
    logic                     avs_read;
    logic                     avs_write;
    logic [31:0]              avs_writedata;
    logic [3:0]               avs_byteenable;
    logic [31:0]              avs_readdata;
    logic                     avs_waitrequest;
    rsph_pkg::rsph_events_s   events = '0;
    logic                     header_valid;
    logic [31:0]              header_word;
    rsph_pkg::rsph_header_s   header_out;
    rsph_pkg::rsph_ctx_info_s ctx_out;
    logic                     header_out_valid;
    logic                     packet_halt;
    logic                     dma_status;
    logic [26:0]              packet_address;
    logic                     packet_in_main;
    logic                     packet_start;
    logic                     irq;
    int                       n_errors = 0;
    int                       comparisons = 0;
    int                       cycles = 0;
    int                       n_hov = 0;
    int                       n_pst = 0;

    rsph_status_header u_rsph_status_header (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events(events),
        .header_valid(header_valid), .header_word(header_word), .header_out(header_out),
        .ctx_out(ctx_out), .header_out_valid(header_out_valid), .packet_halt(packet_halt),
        .dma_status(dma_status), .packet_address(packet_address), .packet_in_main(packet_in_main),
        .packet_start(packet_start), .irq(irq)
    );

    rsph_host u_rsph_host (
        .sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .header_valid(header_valid), .header_word(header_word)
    );

    always #5 sys_clk = ~sys_clk;

    // pulse counters and the hang limit
    always @(posedge sys_clk) begin
        cycles++;
        if (header_out_valid === 1'b1)
            n_hov++;
        if (packet_start === 1'b1)
            n_pst++;
        if (cycles == 6000) begin
            n_errors++;
            close_out();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
    endfunction

    function automatic logic [6:0] ctx_exp(input logic [31:0] w);
        return {|w[5:4], |w[7:6], |w[9:8], w[31:24] == 8'h00, w[23:22], 1'b0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd(input logic [20:0] a, output logic [31:0] q);
        u_rsph_host.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    endtask

    task automatic wr(input logic [20:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        logic [31:0] q;
        u_rsph_host.xfer(1'b1, a, d, be, q);
    endtask

    task automatic settle(input logic [5:0] ev);
        @(posedge sys_clk);
        events <= ev;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        logic [31:0] q;
        logic [31:0] w;
        logic [31:0] r;
        logic [14:0] pa;
        int          c0;
        r = 32'h58AD_9244;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(STAT_ADDR, q);
        chk(q, 32'h0000_0000, "status after reset");
        settle(6'b111001);
        chk(dma_status, 1'b1, "dma status copy");
        rd(STAT_ADDR, q);
        chk(q, 32'h0000_00A9, "live status bits");
        wr(STAT_ADDR, 32'hFFFF_FFFF);
        rd(STAT_ADDR, q);
        chk(q, 32'h0000_02A9, "read-only bits kept");
        chk(packet_halt, 1'b1, "halt output");
        c0 = n_hov;
        u_rsph_host.send_header(32'h0100_0001);
        repeat (3) @(posedge sys_clk);
        chk(n_hov - c0, 0, "header taken while halted");
        wr(STAT_ADDR, 32'h0000_0000);
        chk(packet_halt, 1'b0, "halt released");
        wr(STAT_ADDR, 32'h0000_0200, 4'hC);
        chk(packet_halt, 1'b0, "upper lanes leave halt alone");
        wr(21'h00_0020, 32'h0000_0200);
        rd(21'h00_0020, q);
        chk(q, 32'h0000_0000, "unmapped read");
        rd(STAT_ADDR, q);
        chk(q, 32'h0000_00A9, "unmapped write ignored");
        settle(6'b000001);
        rd(STAT_ADDR, q);
        chk(q, 32'h0000_0151, "falling edge flags");
        wr(STAT_ADDR, 32'h0000_0150);
        rd(STAT_ADDR, q);
        chk(q, 32'h0000_0001, "flags cleared");
        wr(STAT_ADDR, 32'h0000_0150);
        rd(STAT_ADDR, q);
        chk(q, 32'h0000_0001, "cpu cannot set flags");
        settle(6'b000110);
        settle(6'b000000);
        rd(STAT_ADDR, q);
        chk(q, 32'h0000_0006, "page and vsync flags");
        wr(IRQ_ADDR, 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b1, "enabled flag raises irq");
        wr(IRQ_ADDR, 32'h0000_0018);
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b0, "masked flags");
        c0 = n_pst;
        rd(IRQ_ADDR, q);
        repeat (2) @(posedge sys_clk);
        chk(q, 32'h0000_0018, "irq enable readback");
        chk(n_pst - c0, 0, "register read starts no fetch");
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            pa = r[14:0] | 15'h0008;
            settle({r[20], 5'b00000});
            c0 = n_pst;
            rd({3'h2, pa, 3'h0}, q);
            repeat (2) @(posedge sys_clk);
            chk(q[7], r[20], "poll status bit");
            chk(packet_address, {pa, 12'h000}, "packet address");
            chk(packet_in_main, pa[14], "main memory select");
            chk(n_pst - c0, !r[20], "packet start");
        end
        for (int i = 0; i < 26; i++) begin
            r = lfsr(r);
            w = (i == 24) ? 32'h00FF_FFFF : (i == 25) ? 32'hFFFF_FFFF : {r[31:3], i[2:0]};
            if (i < 24 && w[31:24] == 8'h00)
                w[31:24] = 8'h01;
            c0 = n_hov;
            u_rsph_host.send_header(w);
            repeat (3) @(posedge sys_clk);
            chk(n_hov - c0, 1, "header pulse");
            chk(header_out, w, "header fields");
            chk({25'h0, ctx_out}, {25'h0, ctx_exp(w)}, "context info");
        end
        chk(u_rsph_host.timeouts, 0, "bus answers");
        close_out();
    end
endmodule
